// [logic/crrr_regs.sv]
/*
 Register bank holding channel 1 to 3 conversion results with error
 flags, and the channel 0 and 1 reference counts with their interval
 timers. Assumes the serial register port decodes a transfer into one
 cycle read and write strobes, and that the converter core delivers
 results on CLK_IN as a one cycle valid with its error events.
*/
`timescale 1ns/1ps
`include "crrr_cfg.svh"

module crrr_regs (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic [6:0] REG_ADDR_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [15:0] REG_WDATA_IN,
    output logic [15:0] REG_RDATA_OUT,
    output logic REG_RVALID_OUT,
    input wire logic [2:0] RESULT_VALID_IN,
    input wire logic [83:0] RESULT_IN,
    input wire logic [2:0] UNDERRANGE_IN,
    input wire logic [2:0] OVERRANGE_IN,
    input wire logic [2:0] TIMEOUT_IN,
    input wire logic [2:0] AMPLITUDE_FAULT_IN,
    output logic [15:0] CH0_COUNT_OUT,
    output logic [15:0] CH1_COUNT_OUT,
    output logic CH0_CONV_DONE_OUT,
    output logic CH1_CONV_DONE_OUT
);

    // Count times 16 minus one, the reload value of an interval timer
    function automatic crrr_pkg::crrr_timer_t timer_load(
        input crrr_pkg::crrr_word_t count);
        timer_load = crrr_pkg::crrr_timer_t'({count, 4'h0} - 20'h00001);
    endfunction : timer_load

    // Index of the result channel a high or low word belongs to
    function automatic logic [1:0] chan_of(input logic [6:0] addr);
        chan_of = 2'(({1'b0, addr[6:1]} - 7'h01));
    endfunction : chan_of

    // Result word decodes, used by the capture and the read mux
    function automatic logic is_high_word(input logic [6:0] addr);
        is_high_word = (addr == `CRRR_OFS_CH1_HIGH) ||
                       (addr == `CRRR_OFS_CH2_HIGH) ||
                       (addr == `CRRR_OFS_CH3_HIGH);
    endfunction : is_high_word

    function automatic logic is_low_word(input logic [6:0] addr);
        is_low_word = (addr == `CRRR_OFS_CH1_LOW) ||
                      (addr == `CRRR_OFS_CH2_LOW) ||
                      (addr == `CRRR_OFS_CH3_LOW);
    endfunction : is_low_word

    // Folds one result's error events into a channel's sticky flags
    function automatic crrr_pkg::crrr_flags_t add_events(
        input crrr_pkg::crrr_flags_t held,
        input logic under,
        input logic over,
        input logic timeout,
        input logic ampl);
        add_events = held;
        if (under) begin
            add_events[`CRRR_BIT_UNDER - 12] = 1'b1;
        end
        if (over) begin
            add_events[`CRRR_BIT_OVER - 12] = 1'b1;
        end
        if (timeout) begin
            add_events[`CRRR_BIT_TIMEOUT - 12] = 1'b1;
        end
        if (ampl) begin
            add_events[`CRRR_BIT_AMPL - 12] = 1'b1;
        end
    endfunction : add_events

    crrr_pkg::crrr_result_t result [3];
    crrr_pkg::crrr_result_t next_result [3];
    crrr_pkg::crrr_flags_t flags [3];
    crrr_pkg::crrr_flags_t next_flags [3];
    crrr_pkg::crrr_word_t low_hold [3];
    crrr_pkg::crrr_word_t next_low_hold [3];
    crrr_pkg::crrr_word_t count0;
    crrr_pkg::crrr_word_t count1;
    crrr_pkg::crrr_word_t next_count0;
    crrr_pkg::crrr_word_t next_count1;
    crrr_pkg::crrr_timer_t timer0;
    crrr_pkg::crrr_timer_t timer1;
    crrr_pkg::crrr_timer_t next_timer0;
    crrr_pkg::crrr_timer_t next_timer1;
    crrr_pkg::crrr_word_t rdata;
    crrr_pkg::crrr_word_t next_rdata;
    logic rvalid;
    logic next_rvalid;
    logic done0;
    logic done1;
    logic next_done0;
    logic next_done1;
    logic is_high;
    logic is_low;
    logic [1:0] sel;

    assign is_high = is_high_word(REG_ADDR_IN);
    assign is_low = is_low_word(REG_ADDR_IN);
    assign sel = chan_of(REG_ADDR_IN);

    // Result channels
    always_comb begin
        for (int c = 0; c < 3; c++) begin
            next_result[c] = result[c];
            next_flags[c] = flags[c];
            next_low_hold[c] = low_hold[c];
            // Clear on read first so a same cycle event still lands
            if (REG_RD_IN && is_high && sel == 2'(c)) begin
                next_flags[c] = 4'h0;
                next_low_hold[c] = result[c][15:0];
            end
            if (RESULT_VALID_IN[c]) begin
                next_result[c] = RESULT_IN[c*28 +: 28];
                next_flags[c] = add_events(next_flags[c], UNDERRANGE_IN[c],
                    OVERRANGE_IN[c], TIMEOUT_IN[c], AMPLITUDE_FAULT_IN[c]);
            end
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            for (int c = 0; c < 3; c++) begin
                result[c] <= `CRRR_RESULT_RESET;
                flags[c] <= 4'h0;
                low_hold[c] <= 16'h0000;
            end
        end else begin
            for (int c = 0; c < 3; c++) begin
                result[c] <= next_result[c];
                flags[c] <= next_flags[c];
                low_hold[c] <= next_low_hold[c];
            end
        end
    end

    // Reference counts; results ignore writes entirely
    always_comb begin
        next_count0 = count0;
        next_count1 = count1;
        // Reserved values are stored as written; host keeps them out
        if (REG_WR_IN && REG_ADDR_IN == `CRRR_OFS_CH0_COUNT) begin
            next_count0 = REG_WDATA_IN;
        end
        if (REG_WR_IN && REG_ADDR_IN == `CRRR_OFS_CH1_COUNT) begin
            next_count1 = REG_WDATA_IN;
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            count0 <= `CRRR_COUNT_RESET;
            count1 <= `CRRR_COUNT_RESET;
        end else begin
            count0 <= next_count0;
            count1 <= next_count1;
        end
    end

    // Interval timers; a new count applies from the next interval
    always_comb begin
        next_done0 = (timer0 == 20'h00000);
        next_done1 = (timer1 == 20'h00000);
        next_timer0 = next_done0 ? timer_load(count0) : timer0 - 20'h00001;
        next_timer1 = next_done1 ? timer_load(count1) : timer1 - 20'h00001;
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            timer0 <= `CRRR_TIMER_RESET;
            timer1 <= `CRRR_TIMER_RESET;
            done0 <= 1'b0;
            done1 <= 1'b0;
        end else begin
            timer0 <= next_timer0;
            timer1 <= next_timer1;
            done0 <= next_done0;
            done1 <= next_done1;
        end
    end

    // Read path, answered one cycle after the strobe
    always_comb begin
        next_rvalid = REG_RD_IN;
        next_rdata = rdata;
        if (REG_RD_IN) begin
            next_rdata = 16'h0000;
            if (is_high) begin
                next_rdata = {flags[sel],
                    result[sel][27:16]};
            end else if (is_low) begin
                // Held half keeps both words from one conversion
                next_rdata = low_hold[sel];
            end else if (REG_ADDR_IN == `CRRR_OFS_CH0_COUNT) begin
                next_rdata = count0;
            end else if (REG_ADDR_IN == `CRRR_OFS_CH1_COUNT) begin
                next_rdata = count1;
            end
        end
    end

    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rdata <= 16'h0000;
            rvalid <= 1'b0;
        end else begin
            rdata <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    assign REG_RDATA_OUT = rdata;
    assign REG_RVALID_OUT = rvalid;
    assign CH0_COUNT_OUT = count0;
    assign CH1_COUNT_OUT = count1;
    assign CH0_CONV_DONE_OUT = done0;
    assign CH1_CONV_DONE_OUT = done1;

endmodule : crrr_regs

// [pkg/crrr_cfg.svh]
/*
 Constants of the conversion result and reference count register bank:
 register offsets, field positions, reset values and timing counts.
 Assumes it is included by its bare name wherever these are needed.
*/
`ifndef CRRR_CFG_SVH
`define CRRR_CFG_SVH

`define CRRR_ADDR_W 7
`define CRRR_OFS_CH1_HIGH 7'h02
`define CRRR_OFS_CH1_LOW 7'h03
`define CRRR_OFS_CH2_HIGH 7'h04
`define CRRR_OFS_CH2_LOW 7'h05
`define CRRR_OFS_CH3_HIGH 7'h06
`define CRRR_OFS_CH3_LOW 7'h07
`define CRRR_OFS_CH0_COUNT 7'h08
`define CRRR_OFS_CH1_COUNT 7'h09

`define CRRR_BIT_UNDER 15
`define CRRR_BIT_OVER 14
`define CRRR_BIT_TIMEOUT 13
`define CRRR_BIT_AMPL 12
`define CRRR_HIGH_MSB 11

`define CRRR_COUNT_RESET 16'h0080
`define CRRR_RESULT_RESET 28'h0000000
`define CRRR_CLKS_PER_COUNT 16
`define CRRR_TIMER_W 20
`define CRRR_TIMER_RESET 20'h007ff

`endif

// [pkg/crrr_pkg.sv]
/*
 Types shared by the conversion result and reference count register bank.
 Assumes crrr_cfg.svh supplies the numeric constants.
*/
package crrr_pkg;
    typedef logic [15:0] crrr_word_t;
    typedef logic [27:0] crrr_result_t;
    typedef logic [3:0] crrr_flags_t;
    typedef logic [19:0] crrr_timer_t;
endpackage : crrr_pkg

// [tb/crrr_host.sv]
/* Host model driving the register port strobes.
 Assumes each call starts just after a falling clock edge. */
`timescale 1ns/1ps
module crrr_host (
    input wire logic clk_in,
    input wire logic [16:0] ans_in,
    output logic [6:0] addr_out = 7'h00,
    output logic wr_out = 1'b0,
    output logic rd_out = 1'b0,
    output logic [15:0] wdata_out = 16'h0000
);
    // Strobe held to the next call, so transfers may run back to back
    task automatic xfer(input logic w, input logic [6:0] a,
        input logic [15:0] d, output logic [16:0] r);
        wr_out = w;
        rd_out = !w;
        addr_out = a;
        wdata_out = d;
        @(negedge clk_in);
        r = ans_in;
    endtask : xfer
    // Strobes drop low; address and data lines show the inverse of their last value
    task automatic idle();
        wr_out = 1'b0;
        rd_out = 1'b0;
        addr_out = ~addr_out;
        wdata_out = ~wdata_out;
        @(negedge clk_in);
    endtask : idle
endmodule : crrr_host

// [tb/crrr_regs_props.sv]
/* Port assertions for the result and reference count bank.
 Assumes it is bound to every crrr_regs instance. */
`timescale 1ns/1ps
module crrr_props (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic [6:0] REG_ADDR_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [15:0] REG_WDATA_IN,
    input wire logic [15:0] REG_RDATA_OUT,
    input wire logic REG_RVALID_OUT,
    input wire logic [2:0] RESULT_VALID_IN,
    input wire logic [2:0] UNDERRANGE_IN,
    input wire logic [15:0] CH0_COUNT_OUT,
    input wire logic [15:0] CH1_COUNT_OUT,
    input wire logic CH0_CONV_DONE_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    rd_answer_a: assert property (REG_RD_IN |=> REG_RVALID_OUT)
        else $error("read answer missing");
    no_answer_a: assert property (!REG_RD_IN |=> !REG_RVALID_OUT)
        else $error("read answer without read");
    data_hold_a: assert property (!REG_RD_IN |=> $stable(REG_RDATA_OUT))
        else $error("read data moved without read");
    flag_clear_a: assert property ((REG_RD_IN && REG_ADDR_IN == 7'h02
        && !RESULT_VALID_IN[0]) ##1 (REG_RD_IN && REG_ADDR_IN == 7'h02)
        |=> REG_RDATA_OUT[15:12] == 4'h0) else $error("flags not cleared");
    under_set_a: assert property ((RESULT_VALID_IN[0] && UNDERRANGE_IN[0])
        ##1 (REG_RD_IN && REG_ADDR_IN == 7'h02) |=> REG_RDATA_OUT[15])
        else $error("under-range flag lost");
    cnt_write_a: assert property ((REG_WR_IN && REG_ADDR_IN == 7'h08)
        |=> CH0_COUNT_OUT == $past(REG_WDATA_IN)) else $error("count0 write");
    cnt_hold_a: assert property (!(REG_WR_IN && REG_ADDR_IN == 7'h09)
        |=> $stable(CH1_COUNT_OUT)) else $error("count1 moved");
    done_gap_a: assert property (CH0_CONV_DONE_OUT
        |=> !CH0_CONV_DONE_OUT [*8]) else $error("done pulses too close");
    cover property (REG_RD_IN && REG_ADDR_IN == 7'h03);
    cover property (CH0_CONV_DONE_OUT);
    cover property (RESULT_VALID_IN[2]);
    cover property (RESULT_VALID_IN[0] && REG_RD_IN && REG_ADDR_IN == 7'h02);
endmodule : crrr_props
bind crrr_regs crrr_props crrr_props_inst (.*);

// [tb/tb_top.sv]
/* Self-checking bench with an array and queue reference model of the bank.
 Assumes crrr_host drives the register port. */
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] vld = 3'h0;
    logic [83:0] res = '0;
    logic [11:0] ev = '0;
    logic [6:0] addr, a;
    logic wr, rd, rvalid, d0, d1;
    logic [15:0] wdata, rdata;
    logic [15:0] cnt0, cnt1;
    logic [15:0] exp_q [$];
    logic [27:0] mres [3] = '{default: '0};
    logic [3:0] mflg [3] = '{default: '0};
    logic [15:0] mlow [3] = '{default: '0};
    logic [15:0] mcnt [2] = '{default: 16'h0080};
    int unsigned seed = 88847;
    int checks = 0, err_total = 0, c;
    always #25 clk = ~clk;
    crrr_regs crrr_regs_inst (.CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_WDATA_IN(wdata),
        .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
        .RESULT_VALID_IN(vld), .RESULT_IN(res), .UNDERRANGE_IN(ev[2:0]),
        .OVERRANGE_IN(ev[5:3]), .TIMEOUT_IN(ev[8:6]),
        .AMPLITUDE_FAULT_IN(ev[11:9]), .CH0_COUNT_OUT(cnt0),
        .CH1_COUNT_OUT(cnt1),
        .CH0_CONV_DONE_OUT(d0), .CH1_CONV_DONE_OUT(d1));
    crrr_host crrr_host_inst (.clk_in(clk), .ans_in({rvalid, rdata}),
        .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
    function automatic int unsigned rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input string n, input logic [16:0] e, g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic rdm(input logic [6:0] ad);
        logic [16:0] r;
        logic [15:0] e;
        int k;
        k = int'(ad >> 1) - 1;
        case (ad)
            7'h02, 7'h04, 7'h06: begin
                e = {mflg[k], mres[k][27:16]};
                mflg[k] = 4'h0;
                mlow[k] = mres[k][15:0];
            end
            7'h03, 7'h05, 7'h07: e = mlow[k];
            7'h08: e = mcnt[0];
            7'h09: e = mcnt[1];
            default: e = 16'h0000;
        endcase
        exp_q.push_back(e);
        crrr_host_inst.xfer(1'b0, ad, 16'h0000, r);
        chk("read", {1'b1, exp_q.pop_front()}, r);
    endtask : rdm
    task automatic wrm(input logic [6:0] ad, input logic [15:0] d);
        logic [16:0] r;
        crrr_host_inst.xfer(1'b1, ad, d, r);
        if (ad == 7'h08 || ad == 7'h09) mcnt[ad[0]] = d;
        chk("count0", {1'b0, mcnt[0]}, {1'b0, cnt0});
        chk("count1", {1'b0, mcnt[1]}, {1'b0, cnt1});
    endtask : wrm
    // Result pulse; with rd_too the high word is read in that same cycle
    task automatic put(input int ch, input logic [27:0] v,
        input logic [3:0] f, input bit rd_too);
        logic [16:0] r;
        logic [15:0] e;
        crrr_host_inst.idle();
        e = {mflg[ch], mres[ch][27:16]};
        vld[ch] = 1'b1;
        res[ch*28 +: 28] = v;
        ev = '0;
        {ev[ch], ev[ch+3], ev[ch+6], ev[ch+9]} = f;
        if (rd_too) begin
            // Set wins over the clear: old flags out, new ones stay
            mflg[ch] = 4'h0;
            mlow[ch] = mres[ch][15:0];
            crrr_host_inst.xfer(1'b0, 7'(2 + 2 * ch), 16'h0000, r);
        end else begin
            @(negedge clk);
        end
        vld = 3'h0;
        res = ~res;
        ev = ~ev;
        mres[ch] = v;
        mflg[ch] |= f;
        if (rd_too) chk("same cycle read", {1'b1, e}, r);
    endtask : put
    // Reload lag: first pulse may still use the old count, so time the next
    task automatic gap(input logic ch, input int n);
        int k;
        k = 0;
        while ((ch ? d1 : d0) !== 1'b1 && k < 5000) begin
            @(negedge clk);
            k++;
        end
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while ((ch ? d1 : d0) !== 1'b1 && k < 5000);
        chk("interval", 17'(n), 17'(k));
    endtask : gap
    task automatic test_done();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        for (int i = 2; i < 10; i++) rdm(7'(i));
        $display("reset values test end");
        wrm(7'h08, 16'h0005);
        wrm(7'h09, 16'h0007);
        crrr_host_inst.idle();
        gap(1'b0, 80);
        gap(1'b1, 112);
        $display("interval test end");
        repeat (200) begin
            c = int'(rnd() % 3);
            a = 7'(2 + 2 * c);
            put(c, 28'(rnd()), 4'(rnd()), rnd() % 2 == 1);
            rdm(a);
            rdm(a);
            put(c, 28'(rnd()), 4'h0, 1'b0);
            rdm(a + 7'h01);
            a = 7'(2 + rnd() % 8);
            wrm(a, 16'(5 + rnd() % 65531));
            rdm(a < 7'h08 ? {a[6:1], 1'b0} : a);
            rdm(7'(10 + rnd() % 118));
        end
        $display("random traffic test end");
        test_done();
    end
    initial begin
        #(50 * 20000);
        err_total++;
        test_done();
    end
endmodule : tb_top
